/* File: rtl/clk_rate_ctrl.sv */
// Clock and sample-rate control block with APB slave, output dividers, rate detector
//
// The APB register port is this design's own decision.
module clk_rate_ctrl (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Frame clocks of the three interfaces, sampled on pclk
  input  wire logic [2:0]  frame_clk_in,
  // Main-domain rate status from the interface logic
  input  wire logic [4:0]  main_rate_stat_one_in,
  input  wire logic [4:0]  main_rate_stat_two_in,
  input  wire logic [4:0]  main_rate_stat_three_in,
  // Clock configuration outputs
  output logic [2:0]       second_clock_freq_code,
  output logic             second_clock_enable,
  output logic [3:0]       second_clock_source_sel,
  output logic [4:0]       second_rate_sel_one,
  output logic [4:0]       second_rate_sel_two,
  output logic [4:0]       main_rate_sel_two,
  output logic [4:0]       main_rate_sel_three,
  output logic [2:0]       main_clock_out_freq_sel,
  output logic [2:0]       second_clock_out_freq_sel,
  output logic             master_in_one_pulldown,
  output logic             master_in_two_pulldown,
  // Divided clock outputs
  output logic             main_clock_out,
  output logic             second_clock_out,
  // Detector results
  output logic [4:0]       detected_rate,
  output logic             seq_trigger
);

  typedef struct packed {
    logic [2:0]  freq;
    logic        ena;
    logic [3:0]  src;
    logic [4:0]  ssel1;
    logic [4:0]  ssel2;
    logic [4:0]  msel2;
    logic [4:0]  msel3;
    logic [4:0]  mstat1;
    logic [4:0]  mstat2;
    logic [4:0]  mstat3;
    logic [4:0]  sstat1;
    logic [4:0]  sstat2;
    logic        mo_ena;
    logic [4:0]  mo_div;
    logic [2:0]  mo_sel;
    logic        so_ena;
    logic [4:0]  so_div;
    logic [2:0]  so_sel;
    logic        det_trig;
    logic [2:0]  det_src;
    logic        det_ena;
    logic [19:0] cand;
    logic        pd_two;
    logic        pd_one;
    logic [4:0]  mo_cnt;
    logic        mo_clk;
    logic [4:0]  so_cnt;
    logic        so_clk;
    logic        fr_last;
    logic [19:0] per_cnt;
    logic        seen_first;
    logic [4:0]  det_rate;
    logic        trig;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } state_t;

  state_t q, d;

  logic        fr_sel;
  logic [11:0] idx;
  logic        wr_acc;
  logic        rd_acc;
  logic [4:0]  best;
  logic        hit;
  logic        map_ok;
  logic [31:0] rmux;
  logic [4:0]  mo_lim;
  logic [4:0]  so_lim;

  // Rate code to frame period in pclk cycles; zero for none or reserved
  function automatic logic [19:0] rate_period(input logic [4:0] c);
    logic [19:0] p;
    p = 20'h00000;
    case (c)
      5'h01: p = 20'h0411B;
      5'h02: p = 20'h0208D;
      5'h03: p = 20'h01046;
      5'h04: p = 20'h00823;
      5'h05: p = 20'h00411;
      5'h09: p = 20'h046DC;
      5'h0A: p = 20'h0236E;
      5'h0B: p = 20'h011B7;
      5'h0C: p = 20'h008DB;
      5'h0D: p = 20'h0046D;
      5'h11: p = 20'h061A8;
      5'h12: p = 20'h030D4;
      5'h13: p = 20'h0186A;
      default: p = 20'h00000;
    endcase
    return p;
  endfunction : rate_period

  function automatic logic [19:0] absdiff(input logic [19:0] a, input logic [19:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // Detector source mux; reserved codes select no input
  always_comb begin
    case (q.det_src)
      clk_rate_pkg::DET_IF_ONE: fr_sel = frame_clk_in[0];
      clk_rate_pkg::DET_IF_TWO: fr_sel = frame_clk_in[1];
      clk_rate_pkg::DET_IF_THR: fr_sel = frame_clk_in[2];
      default:                  fr_sel = 1'b0;
    endcase
  end

  // Nearest non-zero candidate; zero fields are skipped
  always_comb begin
    logic [19:0] bd;
    logic [19:0] dd;
    bd   = 20'hFFFFF;
    dd   = 20'h00000;
    best = clk_rate_pkg::RATE_NONE;
    hit  = 1'b0;
    for (int i = 0; i < clk_rate_pkg::NUM_CAND; i++) begin
      if (q.cand[i*5 +: 5] != clk_rate_pkg::RATE_NONE &&
          rate_period(q.cand[i*5 +: 5]) != 20'h00000) begin
        dd = absdiff(q.per_cnt, rate_period(q.cand[i*5 +: 5]));
        if (!hit || dd < bd) begin
          bd   = dd;
          best = q.cand[i*5 +: 5];
          hit  = 1'b1;
        end
      end
    end
  end

  // Register index decode and read mux
  assign idx    = paddr[13:2];
  // Writes land on the completing edge, the one at which pready is seen high
  assign wr_acc = psel && penable && pwrite && q.rdy;
  assign rd_acc = psel && penable && !pwrite && !q.rdy;
  always_comb begin
    map_ok = 1'b1;
    rmux   = 32'h00000000;
    case (idx)
      clk_rate_pkg::IDX_MAIN_SEL_TWO:   rmux[4:0] = q.msel2;
      clk_rate_pkg::IDX_MAIN_SEL_THREE: rmux[4:0] = q.msel3;
      clk_rate_pkg::IDX_MAIN_STAT_ONE:  rmux[4:0] = q.mstat1;
      clk_rate_pkg::IDX_MAIN_STAT_TWO:  rmux[4:0] = q.mstat2;
      clk_rate_pkg::IDX_MAIN_STAT_THR:  rmux[4:0] = q.mstat3;
      clk_rate_pkg::IDX_SEC_CFG: begin
        rmux[10:8] = q.freq;
        rmux[6]    = q.ena;
        rmux[3:0]  = q.src;
      end
      clk_rate_pkg::IDX_SEC_SEL_ONE:  rmux[4:0] = q.ssel1;
      clk_rate_pkg::IDX_SEC_SEL_TWO:  rmux[4:0] = q.ssel2;
      clk_rate_pkg::IDX_SEC_STAT_ONE: rmux[4:0] = q.sstat1;
      clk_rate_pkg::IDX_SEC_STAT_TWO: rmux[4:0] = q.sstat2;
      clk_rate_pkg::IDX_MAIN_OUT: begin
        rmux[15]  = q.mo_ena;
        rmux[7:3] = q.mo_div;
        rmux[2:0] = q.mo_sel;
      end
      clk_rate_pkg::IDX_SEC_OUT: begin
        rmux[15]  = q.so_ena;
        rmux[7:3] = q.so_div;
        rmux[2:0] = q.so_sel;
      end
      clk_rate_pkg::IDX_DET_CTRL: begin
        rmux[4]   = q.det_trig;
        rmux[3:1] = q.det_src;
        rmux[0]   = q.det_ena;
      end
      clk_rate_pkg::IDX_CAND_A: rmux[4:0] = q.cand[4:0];
      clk_rate_pkg::IDX_CAND_B: rmux[4:0] = q.cand[9:5];
      clk_rate_pkg::IDX_CAND_C: rmux[4:0] = q.cand[14:10];
      clk_rate_pkg::IDX_CAND_D: rmux[4:0] = q.cand[19:15];
      clk_rate_pkg::IDX_PAD_ONE: rmux[13] = q.pd_two;
      clk_rate_pkg::IDX_PAD_TWO: rmux[12] = q.pd_one;
      default: map_ok = 1'b0;
    endcase
  end

  // Divide-by-one for codes 0 and 1, else toggle every n cycles, odd or even
  assign mo_lim = (q.mo_div < 5'h02) ? 5'h01 : q.mo_div;
  assign so_lim = (q.so_div < 5'h02) ? 5'h01 : q.so_div;

  // Next-state logic
  always_comb begin
    d      = q;
    d.rdy  = 1'b0;
    d.err  = 1'b0;
    // One wait state: answer in the cycle after access phase starts
    if (psel && penable && !q.rdy) begin
      d.rdy   = 1'b1;
      d.err   = !map_ok;
      d.rdata = (rd_acc && map_ok) ? rmux : 32'h00000000;
    end
    if (wr_acc && map_ok) begin
      case (idx)
        clk_rate_pkg::IDX_MAIN_SEL_TWO:   d.msel2 = pwdata[4:0];
        clk_rate_pkg::IDX_MAIN_SEL_THREE: d.msel3 = pwdata[4:0];
        clk_rate_pkg::IDX_SEC_CFG: begin
          d.freq = pwdata[clk_rate_pkg::FREQ_LSB +: 3];
          d.ena  = pwdata[clk_rate_pkg::ENA_BIT];
          d.src  = pwdata[3:0];
        end
        clk_rate_pkg::IDX_SEC_SEL_ONE: d.ssel1 = pwdata[4:0];
        clk_rate_pkg::IDX_SEC_SEL_TWO: d.ssel2 = pwdata[4:0];
        clk_rate_pkg::IDX_MAIN_OUT: begin
          d.mo_ena = pwdata[clk_rate_pkg::OUT_ENA];
          d.mo_div = pwdata[clk_rate_pkg::DIV_LSB +: 5];
          d.mo_sel = pwdata[2:0];
        end
        clk_rate_pkg::IDX_SEC_OUT: begin
          d.so_ena = pwdata[clk_rate_pkg::OUT_ENA];
          d.so_div = pwdata[clk_rate_pkg::DIV_LSB +: 5];
          d.so_sel = pwdata[2:0];
        end
        clk_rate_pkg::IDX_DET_CTRL: begin
          d.det_trig = pwdata[clk_rate_pkg::TRIG_BIT];
          d.det_src  = pwdata[clk_rate_pkg::SRC_LSB +: 3];
          d.det_ena  = pwdata[clk_rate_pkg::DET_ENA];
        end
        clk_rate_pkg::IDX_CAND_A: d.cand[4:0]   = pwdata[4:0];
        clk_rate_pkg::IDX_CAND_B: d.cand[9:5]   = pwdata[4:0];
        clk_rate_pkg::IDX_CAND_C: d.cand[14:10] = pwdata[4:0];
        clk_rate_pkg::IDX_CAND_D: d.cand[19:15] = pwdata[4:0];
        clk_rate_pkg::IDX_PAD_ONE: d.pd_two = pwdata[clk_rate_pkg::PD_TWO_BIT];
        clk_rate_pkg::IDX_PAD_TWO: d.pd_one = pwdata[clk_rate_pkg::PD_ONE_BIT];
        default: d.err = 1'b0;
      endcase
    end
    // Status mirrors of the interface logic
    d.mstat1 = main_rate_stat_one_in;
    d.mstat2 = main_rate_stat_two_in;
    d.mstat3 = main_rate_stat_three_in;
    // Output clock dividers; odd ratios keep an even duty, each half lasting n cycles
    if (!q.mo_ena) begin
      d.mo_cnt = 5'h00;
      d.mo_clk = 1'b0;
    end else if (mo_lim == 5'h01) begin
      d.mo_clk = ~q.mo_clk;
    end else if (q.mo_cnt >= mo_lim - 5'h01) begin
      d.mo_cnt = 5'h00;
      d.mo_clk = ~q.mo_clk;
    end else begin
      d.mo_cnt = q.mo_cnt + 5'h01;
    end
    if (!q.so_ena || !q.ena) begin
      d.so_cnt = 5'h00;
      d.so_clk = 1'b0;
    end else if (so_lim == 5'h01) begin
      d.so_clk = ~q.so_clk;
    end else if (q.so_cnt >= so_lim - 5'h01) begin
      d.so_cnt = 5'h00;
      d.so_clk = ~q.so_clk;
    end else begin
      d.so_cnt = q.so_cnt + 5'h01;
    end
    // Rate detector: period between rising frame edges
    d.trig    = 1'b0;
    // Edge memory tracks the line while off, so enabling on a high line is no edge
    d.fr_last = fr_sel;
    if (!q.det_ena) begin
      d.per_cnt    = 20'h00000;
      d.seen_first = 1'b0;
    end else if (fr_sel && !q.fr_last) begin
      d.per_cnt = 20'h00001;
      if (q.per_cnt != 20'h00000 && hit) begin
        d.det_rate   = best;
        d.sstat1     = best;
        d.seen_first = 1'b1;
        d.trig       = q.seen_first || q.det_trig;
      end
    end else if (q.per_cnt != 20'hFFFFF && q.per_cnt != 20'h00000) begin
      d.per_cnt = q.per_cnt + 20'h00001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.freq  <= clk_rate_pkg::FREQ_RST;
      q.src   <= clk_rate_pkg::SRC_RST;
      q.ssel1 <= clk_rate_pkg::RATE_RST;
      q.ssel2 <= clk_rate_pkg::RATE_RST;
      q.msel2 <= clk_rate_pkg::RATE_RST;
      q.msel3 <= clk_rate_pkg::RATE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign prdata                    = q.rdata;
  assign pready                    = q.rdy;
  assign pslverr                   = q.err;
  assign second_clock_freq_code    = q.freq;
  assign second_clock_enable       = q.ena;
  assign second_clock_source_sel   = q.src;
  assign second_rate_sel_one       = q.ssel1;
  assign second_rate_sel_two       = q.ssel2;
  assign main_rate_sel_two         = q.msel2;
  assign main_rate_sel_three       = q.msel3;
  assign main_clock_out_freq_sel   = q.mo_sel;
  assign second_clock_out_freq_sel = q.so_sel;
  assign master_in_one_pulldown    = q.pd_one;
  assign master_in_two_pulldown    = q.pd_two;
  assign main_clock_out            = q.mo_clk;
  assign second_clock_out          = q.so_clk;
  assign detected_rate             = q.det_rate;
  assign seq_trigger               = q.trig;

  // Checks
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready) else $error("apb no answer");
  det_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.det_ena |=> !seq_trigger) else $error("trigger while off");
  first_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    seq_trigger && !$past(q.seen_first) |-> $past(q.det_trig)) else $error("first trig");
  div_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.mo_ena |=> !main_clock_out) else $error("main clk when off");
  div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mo_ena && $past(q.mo_ena) && mo_lim == 5'h01 && $stable(q.mo_div)
    |=> main_clock_out != $past(main_clock_out)) else $error("div one");
  sdiv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.so_ena || !q.ena |=> !second_clock_out) else $error("sec clk when off");
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !map_ok |=> pslverr) else $error("no slverr");
  // Detected status moves only on a detector edge, never through a bus write
  stat_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.sstat1) |-> $past(q.det_ena && fr_sel && !q.fr_last))
    else $error("status written");
  cv_write_c: cover property (@(posedge pclk) wr_acc && idx == clk_rate_pkg::IDX_SEC_CFG);
  cv_detect_c: cover property (@(posedge pclk) seq_trigger);
  cv_div_c: cover property (@(posedge pclk) q.mo_ena && q.mo_div == 5'h03 && main_clock_out);

endmodule : clk_rate_ctrl

/* File: rtl/clk_rate_pkg.sv */
// Package with register map, field positions, reset values, clock rate and detector count width
package clk_rate_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [11:0] IDX_MAIN_SEL_TWO   = 12'h103;
  localparam logic [11:0] IDX_MAIN_SEL_THREE = 12'h104;
  localparam logic [11:0] IDX_MAIN_STAT_ONE  = 12'h10A;
  localparam logic [11:0] IDX_MAIN_STAT_TWO  = 12'h10B;
  localparam logic [11:0] IDX_MAIN_STAT_THR  = 12'h10C;
  localparam logic [11:0] IDX_SEC_CFG        = 12'h112;
  localparam logic [11:0] IDX_SEC_SEL_ONE    = 12'h113;
  localparam logic [11:0] IDX_SEC_SEL_TWO    = 12'h114;
  localparam logic [11:0] IDX_SEC_STAT_ONE   = 12'h11B;
  localparam logic [11:0] IDX_SEC_STAT_TWO   = 12'h11C;
  localparam logic [11:0] IDX_MAIN_OUT       = 12'h149;
  localparam logic [11:0] IDX_SEC_OUT        = 12'h14A;
  localparam logic [11:0] IDX_DET_CTRL       = 12'h152;
  localparam logic [11:0] IDX_CAND_A         = 12'h153;
  localparam logic [11:0] IDX_CAND_B         = 12'h154;
  localparam logic [11:0] IDX_CAND_C         = 12'h155;
  localparam logic [11:0] IDX_CAND_D         = 12'h156;
  localparam logic [11:0] IDX_PAD_ONE        = 12'hC20;
  localparam logic [11:0] IDX_PAD_TWO        = 12'hC21;
  localparam int          NUM_CAND           = 4;
  // Field positions
  localparam int FREQ_LSB   = 8;
  localparam int ENA_BIT    = 6;
  localparam int OUT_ENA    = 15;
  localparam int DIV_LSB    = 3;
  localparam int TRIG_BIT   = 4;
  localparam int SRC_LSB    = 1;
  localparam int DET_ENA    = 0;
  localparam int PD_TWO_BIT = 13;
  localparam int PD_ONE_BIT = 12;
  // Reset values and the code for no rate
  localparam logic [2:0] FREQ_RST = 3'h3;
  localparam logic [3:0] SRC_RST  = 4'h5;
  localparam logic [4:0] RATE_RST = 5'h11;
  localparam logic [4:0] RATE_NONE = 5'h00;
  // Source select codes
  localparam logic [3:0] SRC_MCLK_ONE = 4'h0;
  localparam logic [3:0] SRC_MCLK_TWO = 4'h1;
  localparam logic [3:0] SRC_LOOP_ONE = 4'h4;
  localparam logic [3:0] SRC_LOOP_TWO = 4'h5;
  localparam logic [3:0] SRC_BCLK_ONE = 4'h8;
  localparam logic [3:0] SRC_BCLK_TWO = 4'h9;
  localparam logic [3:0] SRC_BCLK_THR = 4'hA;
  localparam logic [2:0] DET_IF_ONE = 3'h0;
  localparam logic [2:0] DET_IF_TWO = 3'h2;
  localparam logic [2:0] DET_IF_THR = 3'h4;
  // Timing: clock rate and detector count width
  localparam int CLK_MHZ   = 200;
  localparam int PER_W     = 20;
endpackage : clk_rate_pkg

/* File: tb/tb_async_clock_rate_control.sv */
// Self-checking testbench for the clock and sample-rate control block
module tb_async_clock_rate_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic [2:0]  frame_clk_in = 3'h0;
  logic [4:0]  stat_one = 5'h00, stat_two = 5'h00, stat_thr = 5'h00;
  logic [2:0]  sc_freq, mo_sel, so_sel;
  logic [3:0]  sc_src;
  logic [4:0]  sr_one, sr_two, mr_two, mr_thr, det_rate;
  logic        sc_ena, pd_one, pd_two, mo_clk, so_clk, seq_trig;
  logic [2:0]  fr_mask = 3'h0;
  int          fr_per = 4167, fr_cnt = 0, fail_count = 0, checks = 0;
  logic [31:0] rd;
  logic        err;

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  clk_rate_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_clk_in(frame_clk_in), .main_rate_stat_one_in(stat_one),
    .main_rate_stat_two_in(stat_two), .main_rate_stat_three_in(stat_thr),
    .second_clock_freq_code(sc_freq), .second_clock_enable(sc_ena),
    .second_clock_source_sel(sc_src), .second_rate_sel_one(sr_one),
    .second_rate_sel_two(sr_two), .main_rate_sel_two(mr_two), .main_rate_sel_three(mr_thr),
    .main_clock_out_freq_sel(mo_sel), .second_clock_out_freq_sel(so_sel),
    .master_in_one_pulldown(pd_one), .master_in_two_pulldown(pd_two),
    .main_clock_out(mo_clk), .second_clock_out(so_clk), .detected_rate(det_rate),
    .seq_trigger(seq_trig)
  );

  // Frame clock of the far interface; idles low when no lane is selected
  always @(posedge pclk) begin
    fr_cnt       <= (fr_cnt >= fr_per - 1) ? 0 : fr_cnt + 1;
    frame_clk_in <= (fr_cnt < fr_per / 2) ? fr_mask : 3'h0;
  end

  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; answer taken at the rising edge where pready is sampled high
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Writes land on this edge; callers look at outputs once they have settled
    @(negedge pclk);
  endtask : apb

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Reset values of every register and of the configuration outputs except mo_sel and so_sel
  task automatic reset_values;
    logic [11:0] idx [19];
    logic [31:0] exp [19];
    idx = '{clk_rate_pkg::IDX_MAIN_SEL_TWO, clk_rate_pkg::IDX_MAIN_SEL_THREE,
            clk_rate_pkg::IDX_MAIN_STAT_ONE, clk_rate_pkg::IDX_MAIN_STAT_TWO,
            clk_rate_pkg::IDX_MAIN_STAT_THR, clk_rate_pkg::IDX_SEC_CFG,
            clk_rate_pkg::IDX_SEC_SEL_ONE, clk_rate_pkg::IDX_SEC_SEL_TWO,
            clk_rate_pkg::IDX_SEC_STAT_ONE, clk_rate_pkg::IDX_SEC_STAT_TWO,
            clk_rate_pkg::IDX_MAIN_OUT, clk_rate_pkg::IDX_SEC_OUT, clk_rate_pkg::IDX_DET_CTRL,
            clk_rate_pkg::IDX_CAND_A, clk_rate_pkg::IDX_CAND_B, clk_rate_pkg::IDX_CAND_C,
            clk_rate_pkg::IDX_CAND_D, clk_rate_pkg::IDX_PAD_ONE, clk_rate_pkg::IDX_PAD_TWO};
    exp = '{32'h11, 32'h11, 32'h0, 32'h0, 32'h0, 32'h305, 32'h11, 32'h11, 32'h0, 32'h0,
            32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 19; i++) begin
      apb(idx[i], 1'b0, 32'h0);
      chk(rd, exp[i]);
    end
    chk({sc_freq, sc_src, sc_ena, pd_one, pd_two}, 32'h1A8);
    chk({sr_one, sr_two, mr_two, mr_thr}, 32'h8C631);
  endtask : reset_values

  // Every source code with a frequency code and the enable bit
  task automatic second_clock_cfg;
    logic [3:0] src [7];
    logic [31:0] w;
    src = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA};
    for (int i = 0; i < 7; i++) begin
      w = {21'h0, 3'(i % 4), 1'b0, 1'(i % 2), 2'b00, src[i]};
      apb(clk_rate_pkg::IDX_SEC_CFG, 1'b1, w);
      apb(clk_rate_pkg::IDX_SEC_CFG, 1'b0, 32'h0);
      chk(rd, w);
      chk({sc_freq, sc_ena, sc_src}, {24'h0, 3'(i % 4), 1'(i % 2), src[i]});
    end
  endtask : second_clock_cfg

  // Rate selectors, pull-downs, status mirroring and read-only status
  task automatic selectors_status;
    apb(clk_rate_pkg::IDX_SEC_SEL_ONE, 1'b1, 32'h0D);
    apb(clk_rate_pkg::IDX_SEC_SEL_TWO, 1'b1, 32'h13);
    apb(clk_rate_pkg::IDX_MAIN_SEL_TWO, 1'b1, 32'h05);
    apb(clk_rate_pkg::IDX_MAIN_SEL_THREE, 1'b1, 32'h09);
    apb(clk_rate_pkg::IDX_PAD_ONE, 1'b1, 32'h2000);
    apb(clk_rate_pkg::IDX_PAD_TWO, 1'b1, 32'h1000);
    chk({sr_one, sr_two, mr_two, mr_thr}, {12'h0, 5'h0D, 5'h13, 5'h05, 5'h09});
    chk({pd_two, pd_one}, 32'h3);
    apb(clk_rate_pkg::IDX_SEC_SEL_TWO, 1'b0, 32'h0);
    chk(rd, 32'h13);
    @(posedge pclk);
    stat_one <= 5'h03;
    stat_two <= 5'h0B;
    stat_thr <= 5'h11;
    apb(clk_rate_pkg::IDX_MAIN_STAT_ONE, 1'b1, 32'h1F);
    apb(clk_rate_pkg::IDX_MAIN_STAT_ONE, 1'b0, 32'h0);
    chk(rd, 32'h03);
    apb(clk_rate_pkg::IDX_MAIN_STAT_TWO, 1'b0, 32'h0);
    chk(rd, 32'h0B);
    apb(clk_rate_pkg::IDX_MAIN_STAT_THR, 1'b0, 32'h0);
    chk(rd, 32'h11);
    apb(12'h105, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(12'h1FF, 1'b1, 32'hFFFF);
    chk({31'h0, err}, 32'h1);
  endtask : selectors_status

  // Half period of a divided clock, counted between two toggles
  task automatic div_case(input logic sec, input logic [4:0] code, input int half);
    logic prev;
    int   n;
    apb(sec ? clk_rate_pkg::IDX_SEC_OUT : clk_rate_pkg::IDX_MAIN_OUT, 1'b1,
        {16'h0, 1'b1, 7'h0, code, 3'h2});
    chk({29'h0, sec ? so_sel : mo_sel}, 32'h2);
    prev = sec ? so_clk : mo_clk;
    for (n = 0; n < 80 && (sec ? so_clk : mo_clk) === prev; n++) @(negedge pclk);
    prev = sec ? so_clk : mo_clk;
    for (n = 0; n < 80 && (sec ? so_clk : mo_clk) === prev; n++) @(negedge pclk);
    chk(n, half);
  endtask : div_case

  // Detector on one lane; counts trigger pulses until the rate is found
  task automatic det_case(input int lane, input int per, input logic [4:0] code,
                          input logic trig, input int exp_pulses);
    int n, p;
    fr_per  <= per;
    fr_mask <= 3'(1 << lane);
    apb(clk_rate_pkg::IDX_DET_CTRL, 1'b1, {27'h0, trig, 3'(2 * lane), 1'b1});
    p = 0;
    for (n = 0; n < 3 * per && det_rate !== code; n++) begin
      @(negedge pclk);
      if (seq_trig === 1'b1) p++;
    end
    chk({27'h0, det_rate}, {27'h0, code});
    if (exp_pulses == 0) chk(p, 0);
    else chk(p > 0, 1);
    // A bus write to the detected status must be ignored
    apb(clk_rate_pkg::IDX_SEC_STAT_ONE, 1'b1, 32'h1F);
    apb(clk_rate_pkg::IDX_SEC_STAT_ONE, 1'b0, 32'h0);
    chk(rd, {27'h0, code});
  endtask : det_case

  // Second output clock with the second clock running, then an orderly shutdown
  task automatic second_out;
    apb(clk_rate_pkg::IDX_SEC_CFG, 1'b1, 32'h345);
    div_case(1'b1, 5'h02, 2);
    apb(clk_rate_pkg::IDX_SEC_OUT, 1'b1, 32'h0);
    apb(clk_rate_pkg::IDX_SEC_CFG, 1'b1, 32'h305);
    chk({30'h0, sc_ena, so_clk}, 32'h0);
  endtask : second_out

  task automatic detector;
    apb(clk_rate_pkg::IDX_CAND_A, 1'b1, 32'h03);
    apb(clk_rate_pkg::IDX_CAND_B, 1'b1, 32'h12);
    apb(clk_rate_pkg::IDX_CAND_C, 1'b1, 32'h13);
    // Detector off: frame clock runs but nothing is reported
    fr_per  <= 6250;
    fr_mask <= 3'h1;
    repeat (13000) @(negedge pclk);
    chk({26'h0, det_rate, seq_trig}, 32'h0);
    det_case(0, 4167, 5'h03, 1'b0, 0);
    det_case(1, 12500, 5'h12, 1'b0, 1);
    det_case(2, 6250, 5'h13, 1'b0, 1);
    fr_mask <= 3'h0;
    do_reset();
    apb(clk_rate_pkg::IDX_CAND_A, 1'b1, 32'h03);
    det_case(0, 4167, 5'h03, 1'b1, 1);
  endtask : detector

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    second_clock_cfg();
    selectors_status();
    div_case(1'b0, 5'h00, 1);
    div_case(1'b0, 5'h01, 1);
    div_case(1'b0, 5'h03, 3);
    div_case(1'b0, 5'h1F, 31);
    second_out();
    detector();
    print_verdict();
  end
endmodule : tb_async_clock_rate_control
